// ### include/dep_pkg.sv
// Constants for the data EEPROM page controller.
// Contract
// - Page mode plus read enable: read start fetches bytes of a 16-byte page.
// - Read start is ignored unless read enable is already high.
// - After each page byte read: clear read start, load data, advance address.
// - Setting read start again fetches the next byte without reloading anything.
// - Page modes: upper 3 address bits fixed; lower 4 increment, stop at 0FH.
// - Page buffer cleared at reset and when wipe enable falls, not when it rises.
// - Page erase: each data write tags current address, value ignored, address advances.
// - Erase ends on internal timer: clear wipe start, then wipe enable.
// - Every erased byte reads back as zero.
// - Byte mode: load address and data, set store enable, then write start.
// - Write start does nothing unless store enable is already high.
// - Byte write erases the addressed byte first, then programs it.
// - Write ends on internal timer: clear write start, then store enable.
// - Store enable falling clears the page buffer; rising leaves it.
// - Page write: data writes fill buffer and advance; writes past saturation discarded.
// - Store enable is clear after reset.
// - Erase or write end sets the rom flag and multi-function flag; enables gate.
// - Servicing clears multi-function flag and global enable; software clears rom flag.
// - Control bits 6..0: wipe_en, wipe_start, mode, store_en, write_start, read_en, read_start.
// - 128 bytes, 7-bit address register, 8-bit data register.
package dep_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int DEPTH = 128;
  localparam int PAGE_BYTES = 16;
  // APB byte addresses
  localparam logic [11:0] OFF_ADDR = 12'h000;
  localparam logic [11:0] OFF_DATA = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_IRQ = 12'h00C;
  // Control field positions
  localparam int B_RD = 0;
  localparam int B_READ_ENABLE = 1;
  localparam int B_WR = 2;
  localparam int B_STORE_ENABLE = 3;
  localparam int B_MODE = 4;
  localparam int B_ER = 5;
  localparam int B_WIPE_ENABLE = 6;
  // Interrupt register field positions
  localparam int B_FLAG = 0;
  localparam int B_MF_FLAG = 1;
  localparam int B_IEN = 2;
  localparam int B_MF_EN = 3;
  localparam int B_GIE = 4;
  localparam int B_SERVICE = 5;
  localparam int B_STACK_FULL = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] LOW_MAX = 4'hF;
  // Internal timer period, ns; cycle length of the bus clock, ns
  localparam int TMR_PERIOD_NS = 30;
  localparam int CLK_NS = 5;
  localparam int TMR_HALF_CYC = (TMR_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
  localparam int PROG_TICKS = 64;
  localparam int READ_CYC = 2;
  typedef enum logic [2:0] {DEP_IDLE, DEP_READ, DEP_ERASE, DEP_BERASE, DEP_PROG, DEP_CLR_ST, DEP_CLR_EN} dep_state_t;
endpackage : dep_pkg

// ### logic/dep_ctrl.sv
// Data EEPROM page controller with APB register access.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dep_ctrl #(
  parameter int PROG_TICKS = dep_pkg::PROG_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_o,
  output logic busy_o
);
  logic [7:0] mem_r [dep_pkg::DEPTH];
  logic [7:0] pbuf_r [dep_pkg::PAGE_BYTES];
  logic [dep_pkg::PAGE_BYTES-1:0] ptag_r;
  logic [6:0] rom_address_reg_r;
  logic [7:0] rom_data_reg_r;
  logic read_start_r, read_enable_r, write_start_r, store_enable_r, mode_r, wipe_start_r, wipe_enable_r;
  logic rom_irq_flag_r, mf_flag_r, rom_irq_enable_r, mf_enable_r, global_irq_enable_r, stack_full_r;
  dep_pkg::dep_state_t state_r;
  logic byte_op_r;
  logic [7:0] cnt_r;
  logic [3:0] tdiv_r;
  logic tmr_clk_r, tmr_s1_r, tmr_s2_r, tmr_s3_r;
  logic cycle_end;
  logic wr_acc, rd_acc, done_pls;
  logic ctrl_wr, data_wr, irq_wr, addr_wr;
  logic [7:0] wctl;
  logic [7:0] ctrl_rd;
  logic [3:0] low;
  logic sat;

  // Advance the low nibble, holding at the page boundary
  function automatic logic [6:0] page_inc(input logic [6:0] a);
    page_inc = (a[3:0] == dep_pkg::LOW_MAX) ? a : {a[6:4], a[3:0] + 4'h1};
  endfunction

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign addr_wr = wr_acc && paddr == dep_pkg::OFF_ADDR;
  assign data_wr = wr_acc && paddr == dep_pkg::OFF_DATA;
  assign ctrl_wr = wr_acc && paddr == dep_pkg::OFF_CTRL;
  assign irq_wr = wr_acc && paddr == dep_pkg::OFF_IRQ;
  assign wctl = pwdata[7:0];
  assign low = rom_address_reg_r[3:0];
  assign sat = ptag_r[low] && low == dep_pkg::LOW_MAX;
  assign ctrl_rd = {1'b0, wipe_enable_r, wipe_start_r, mode_r, store_enable_r, write_start_r,
                    read_enable_r, read_start_r};

  // Free-running internal timer; rate unrelated to the bus clock in a real part
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdiv_r <= 4'h0;
      tmr_clk_r <= 1'b0;
    end else if (tdiv_r == 4'(dep_pkg::TMR_HALF_CYC - 1)) begin
      tdiv_r <= 4'h0;
      tmr_clk_r <= !tmr_clk_r;
    end else begin
      tdiv_r <= tdiv_r + 4'h1;
    end
  end

  // Timer level brought across through two flops, then edge found on the third
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_s1_r <= 1'b0;
      tmr_s2_r <= 1'b0;
      tmr_s3_r <= 1'b0;
    end else begin
      tmr_s1_r <= tmr_clk_r;
      tmr_s2_r <= tmr_s1_r;
      tmr_s3_r <= tmr_s2_r;
    end
  end

  assign cycle_end = tmr_s2_r && !tmr_s3_r && cnt_r == 8'h00;
  assign done_pls = (state_r == dep_pkg::DEP_CLR_EN);

  // Operation sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= dep_pkg::DEP_IDLE;
      cnt_r <= 8'h00;
      byte_op_r <= 1'b0;
    end else begin
      case (state_r)
        dep_pkg::DEP_IDLE: begin
          if (ctrl_wr && wctl[dep_pkg::B_RD] && read_enable_r) begin
            state_r <= dep_pkg::DEP_READ;
            cnt_r <= 8'(dep_pkg::READ_CYC - 1);
          end else if (ctrl_wr && wctl[dep_pkg::B_ER] && wipe_enable_r && mode_r) begin
            state_r <= dep_pkg::DEP_ERASE;
            cnt_r <= 8'(PROG_TICKS - 1);
          end else if (ctrl_wr && wctl[dep_pkg::B_WR] && store_enable_r) begin
            state_r <= mode_r ? dep_pkg::DEP_PROG : dep_pkg::DEP_BERASE;
            byte_op_r <= !mode_r;
            cnt_r <= 8'(PROG_TICKS - 1);
          end
        end
        dep_pkg::DEP_READ: begin
          if (cnt_r == 8'h00) begin
            state_r <= dep_pkg::DEP_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        dep_pkg::DEP_ERASE, dep_pkg::DEP_BERASE, dep_pkg::DEP_PROG: begin
          if (cycle_end) begin
            state_r <= (state_r == dep_pkg::DEP_BERASE) ? dep_pkg::DEP_PROG : dep_pkg::DEP_CLR_ST;
            cnt_r <= 8'(PROG_TICKS - 1);
          end else if (tmr_s2_r && !tmr_s3_r) begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        dep_pkg::DEP_CLR_ST: state_r <= dep_pkg::DEP_CLR_EN;
        dep_pkg::DEP_CLR_EN: state_r <= dep_pkg::DEP_IDLE;
        default: state_r <= dep_pkg::DEP_IDLE;
      endcase
    end
  end

  // Control bits; start bits only stick when their enable was already high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_start_r <= 1'b0;
      read_enable_r <= 1'b0;
      write_start_r <= 1'b0;
      store_enable_r <= 1'b0;
      mode_r <= 1'b0;
      wipe_start_r <= 1'b0;
      wipe_enable_r <= 1'b0;
    end else begin
      if (ctrl_wr && state_r == dep_pkg::DEP_IDLE) begin
        read_enable_r <= wctl[dep_pkg::B_READ_ENABLE];
        mode_r <= wctl[dep_pkg::B_MODE];
        store_enable_r <= wctl[dep_pkg::B_STORE_ENABLE];
        wipe_enable_r <= wctl[dep_pkg::B_WIPE_ENABLE];
        read_start_r <= wctl[dep_pkg::B_RD] && read_enable_r;
        write_start_r <= wctl[dep_pkg::B_WR] && store_enable_r;
        wipe_start_r <= wctl[dep_pkg::B_ER] && wipe_enable_r && mode_r;
      end
      if (state_r == dep_pkg::DEP_READ && cnt_r == 8'h00) begin
        read_start_r <= 1'b0;
      end
      if (state_r == dep_pkg::DEP_CLR_ST) begin
        write_start_r <= 1'b0;
        wipe_start_r <= 1'b0;
      end
      if (state_r == dep_pkg::DEP_CLR_EN) begin
        store_enable_r <= 1'b0;
        wipe_enable_r <= 1'b0;
      end
    end
  end

  // Address and data registers with page auto-increment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_address_reg_r <= 7'h00;
      rom_data_reg_r <= 8'h00;
    end else if (state_r == dep_pkg::DEP_READ && cnt_r == 8'h00) begin
      rom_data_reg_r <= mem_r[rom_address_reg_r];
      if (mode_r) begin
        rom_address_reg_r <= page_inc(rom_address_reg_r);
      end
    end else if (state_r == dep_pkg::DEP_IDLE) begin
      if (addr_wr) begin
        rom_address_reg_r <= pwdata[6:0];
      end
      if (data_wr) begin
        rom_data_reg_r <= pwdata[7:0];
        if (mode_r && !sat) begin
          rom_address_reg_r <= page_inc(rom_address_reg_r);
        end
      end
    end
  end

  // Page buffer and tags; a write at the held 0FH slot is taken once, later ones dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptag_r <= '0;
      for (int i = 0; i < dep_pkg::PAGE_BYTES; i++) begin
        pbuf_r[i] <= 8'h00;
      end
    end else if ((ctrl_wr && state_r == dep_pkg::DEP_IDLE && wipe_enable_r && !wctl[dep_pkg::B_WIPE_ENABLE])
                 || done_pls
                 || (ctrl_wr && state_r == dep_pkg::DEP_IDLE && store_enable_r && !wctl[dep_pkg::B_STORE_ENABLE])) begin
      ptag_r <= '0;
      for (int i = 0; i < dep_pkg::PAGE_BYTES; i++) begin
        pbuf_r[i] <= 8'h00;
      end
    end else if (data_wr && state_r == dep_pkg::DEP_IDLE && mode_r && !sat) begin
      ptag_r[low] <= 1'b1;
      pbuf_r[low] <= pwdata[7:0];
    end
  end

  // Array: erase leaves zero, program stores buffered or single byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < dep_pkg::DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (cycle_end) begin
      if (state_r == dep_pkg::DEP_BERASE) begin
        mem_r[rom_address_reg_r] <= 8'h00;
      end else if (state_r == dep_pkg::DEP_PROG && byte_op_r) begin
        mem_r[rom_address_reg_r] <= rom_data_reg_r;
      end else if (state_r == dep_pkg::DEP_ERASE || state_r == dep_pkg::DEP_PROG) begin
        // cycle_end also fires in idle and read while the count sits at zero; only page phases may touch the page
        for (int i = 0; i < dep_pkg::PAGE_BYTES; i++) begin
          if (ptag_r[i]) begin
            mem_r[{rom_address_reg_r[6:4], 4'(i)}] <= (state_r == dep_pkg::DEP_ERASE) ? 8'h00 : pbuf_r[i];
          end
        end
      end
    end
  end

  // Interrupt flags; set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_irq_flag_r <= 1'b0;
      mf_flag_r <= 1'b0;
      rom_irq_enable_r <= 1'b0;
      mf_enable_r <= 1'b0;
      global_irq_enable_r <= 1'b0;
      stack_full_r <= 1'b0;
    end else begin
      if (irq_wr) begin
        rom_irq_flag_r <= pwdata[dep_pkg::B_FLAG];
        mf_flag_r <= pwdata[dep_pkg::B_MF_FLAG];
        rom_irq_enable_r <= pwdata[dep_pkg::B_IEN];
        mf_enable_r <= pwdata[dep_pkg::B_MF_EN];
        global_irq_enable_r <= pwdata[dep_pkg::B_GIE];
        stack_full_r <= pwdata[dep_pkg::B_STACK_FULL];
        if (pwdata[dep_pkg::B_SERVICE] && global_irq_enable_r && rom_irq_enable_r && mf_enable_r
            && !stack_full_r) begin
          mf_flag_r <= 1'b0;
          global_irq_enable_r <= 1'b0;
          rom_irq_flag_r <= rom_irq_flag_r;
        end
      end
      if (done_pls) begin
        rom_irq_flag_r <= 1'b1;
        mf_flag_r <= 1'b1;
      end
    end
  end

  // Outputs and APB read data; zero-wait, no errors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_o <= 1'b0;
      busy_o <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      irq_o <= rom_irq_flag_r && mf_flag_r && rom_irq_enable_r && mf_enable_r
               && global_irq_enable_r && !stack_full_r;
      busy_o <= state_r != dep_pkg::DEP_IDLE;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          dep_pkg::OFF_ADDR: prdata <= {25'h0, rom_address_reg_r};
          dep_pkg::OFF_DATA: prdata <= {24'h0, rom_data_reg_r};
          dep_pkg::OFF_CTRL: prdata <= {24'h0, ctrl_rd};
          dep_pkg::OFF_IRQ: prdata <= {25'h0, stack_full_r, 1'b0, global_irq_enable_r, mf_enable_r,
                                       rom_irq_enable_r, mf_flag_r, rom_irq_flag_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end else if (rd_acc) begin
        prdata <= prdata;
      end
    end
  end

  // Bus answer; no wait states and no error responses, held low only in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= 1'b0;
    end
  end
endmodule // dep_ctrl
`default_nettype wire

// ### dv/dep_ctrl_props.sv
// Port checker for the data EEPROM page controller.
`timescale 1ns/1ps
`default_nettype none
module dep_ctrl_props #(
  parameter int PROG_TICKS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_o,
  input wire logic busy_o
);
  // Generous: two timer phases plus synchroniser slack
  localparam int BUSY_MAX = 16 * PROG_TICKS + 96;
  logic [3:0] since_ctl_r;
  logic [3:0] since_evt_r;
  logic [11:0] busy_cnt_r;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Age of last control write, saturating so it never wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_ctl_r <= 4'hF;
    else if (psel && penable && pwrite && paddr == dep_pkg::OFF_CTRL) since_ctl_r <= 4'h0;
    else if (since_ctl_r != 4'hF) since_ctl_r <= since_ctl_r + 4'h1;
  end
  // Age of last busy cycle or interrupt register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_evt_r <= 4'hF;
    else if (busy_o || (psel && penable && pwrite && paddr == dep_pkg::OFF_IRQ)) since_evt_r <= 4'h0;
    else if (since_evt_r != 4'hF) since_evt_r <= since_evt_r + 4'h1;
  end
  // Length of the current busy run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt_r <= 12'h000;
    else busy_cnt_r <= busy_o ? busy_cnt_r + 12'h001 : 12'h000;
  end
  property p_ready; psel |-> pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("slave stalled or flagged an error");
  property p_rst; $rose(presetn) |-> !busy_o && !irq_o; endproperty
  a_rst: assert property (p_rst) else $error("busy or irq right after reset");
  property p_hold; psel && penable && !pwrite |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved after access");
  property p_unmap; psel && !penable && !pwrite && paddr >= 12'h010 |=> prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_addr_w; psel && !penable && !pwrite && paddr == dep_pkg::OFF_ADDR |=> prdata[31:7] == 25'h0; endproperty
  a_addr_w: assert property (p_addr_w) else $error("address wider than 7 bits");
  property p_ctrl_w; psel && !penable && !pwrite && paddr == dep_pkg::OFF_CTRL |=> prdata[31:7] == 25'h0; endproperty
  a_ctrl_w: assert property (p_ctrl_w) else $error("control bit 7 or above set");
  property p_busy_cause; $rose(busy_o) |-> since_ctl_r <= 4'h3; endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without control write");
  property p_busy_bound; busy_cnt_r <= BUSY_MAX; endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("operation never ended");
  property p_irq_cause; $rose(irq_o) |-> since_evt_r <= 4'h3; endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cycle end");
  c_done: cover property ($fell(busy_o));
  c_irq: cover property ($rose(irq_o));
  c_unmap: cover property (psel && !penable && paddr >= 12'h010);
endmodule // dep_ctrl_props
bind dep_ctrl dep_ctrl_props #(.PROG_TICKS(PROG_TICKS)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_o(irq_o), .busy_o(busy_o));
`default_nettype wire

// ### dv/dep_ctrl_tb.sv
// Self-checking bench for the data EEPROM page controller.
`timescale 1ns/1ps
`default_nettype none
module dep_ctrl_tb;
  localparam logic [11:0] A_AD = dep_pkg::OFF_ADDR;
  localparam logic [11:0] A_DT = dep_pkg::OFF_DATA;
  localparam logic [11:0] A_CT = dep_pkg::OFF_CTRL;
  localparam logic [11:0] A_IQ = dep_pkg::OFF_IRQ;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic irq_o;
  logic busy_o;
  int n_fail = 0;
  int comparisons = 0;
  int mem [128];
  int a;
  int d;
  int pg;
  always #2.5 pclk = ~pclk;
  // Short program count keeps the run brief
  dep_ctrl #(.PROG_TICKS(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_o(irq_o), .busy_o(busy_o));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; an idle cycle after it avoids double drives
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      conclude();
    end
    q = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] ad, input int wd);
    apb(1'h1, ad, 32'(wd));
  endtask
  task automatic rd(input logic [11:0] ad);
    apb(1'h0, ad, 32'h0);
  endtask
  // Poll control until it settles, bounded
  task automatic waitc(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      rd(A_CT);
      n++;
    end while (q !== exp && n < 300);
    chk(q, exp);
    if (q !== exp) conclude();
  endtask
  // Page read of the whole page plus one read past the boundary
  task automatic page_chk();
    wr(A_AD, pg);
    wr(A_CT, 32'h12);
    for (int i = 0; i < 17; i++) begin
      wr(A_CT, 32'h13);
      waitc(32'h12);
      rd(A_DT);
      chk(q, 32'(mem[pg + (i > 15 ? 15 : i)]));
      rd(A_AD);
      chk(q, 32'(pg + (i > 14 ? 15 : i + 1)));
    end
    wr(A_CT, 32'h10);
  endtask
  initial begin
    d = $urandom(49607);
    for (int i = 0; i < 128; i++) mem[i] = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      rd(12'(4 * i));
      chk(q, 32'h0);
    end
    wr(A_CT, 32'h01);
    rd(A_CT);
    chk(q, 32'h0);
    wr(A_CT, 32'h04);
    rd(A_CT);
    chk(q, 32'h0);
    $display("test reset and refusals done");
    for (int k = 0; k < 3; k++) begin
      a = $urandom_range(127);
      d = $urandom_range(255);
      wr(A_AD, a);
      wr(A_DT, d);
      wr(A_CT, 32'h08);
      wr(A_CT, 32'h0C);
      waitc(32'h0);
      mem[a] = d;
      rd(A_IQ);
      chk(q & 32'h3, 32'h3);
      wr(A_IQ, 0);
      wr(A_CT, 32'h02);
      wr(A_CT, 32'h03);
      waitc(32'h02);
      rd(A_DT);
      chk(q, 32'(d));
      wr(A_CT, 32'h0);
    end
    $display("test byte write done");
    pg = 16 * $urandom_range(7);
    wr(A_CT, 32'h10);
    wr(A_AD, pg);
    for (int i = 0; i < 18; i++) wr(A_DT, $urandom);
    rd(A_AD);
    chk(q, 32'(pg + 15));
    wr(A_CT, 32'h50);
    wr(A_CT, 32'h70);
    waitc(32'h10);
    for (int i = 0; i < 16; i++) mem[pg + i] = 0;
    page_chk();
    $display("test page erase done");
    // Store enable falling empties the loaded buffer
    wr(A_AD, pg);
    for (int i = 0; i < 4; i++) wr(A_DT, 32'hA5);
    wr(A_CT, 32'h18);
    wr(A_CT, 32'h10);
    wr(A_CT, 32'h18);
    wr(A_CT, 32'h1C);
    waitc(32'h10);
    page_chk();
    wr(A_AD, pg);
    for (int i = 0; i < 17; i++) begin
      d = $urandom_range(255);
      wr(A_DT, d);
      if (i < 16) mem[pg + i] = d;
    end
    wr(A_CT, 32'h18);
    wr(A_CT, 32'h1C);
    waitc(32'h10);
    page_chk();
    // Wipe enable falling empties the tags, so the erase leaves the page alone
    wr(A_AD, pg);
    for (int i = 0; i < 3; i++) wr(A_DT, 32'h5A);
    wr(A_CT, 32'h50);
    wr(A_CT, 32'h10);
    wr(A_CT, 32'h50);
    wr(A_CT, 32'h70);
    waitc(32'h10);
    page_chk();
    $display("test page write done");
    // Registered output: look one edge after the write lands
    wr(A_IQ, 32'h1F);
    @(posedge pclk);
    chk(32'(irq_o), 32'h1);
    wr(A_IQ, 32'h0B);
    @(posedge pclk);
    chk(32'(irq_o), 32'h0);
    // Service strobe acts on the enables as they stand before the write
    wr(A_IQ, 32'h1F);
    wr(A_IQ, 32'h3F);
    rd(A_IQ);
    chk(q, 32'h0D);
    chk(32'(irq_o), 32'h0);
    wr(A_IQ, 32'h0);
    $display("test interrupt done");
    conclude();
  end
endmodule // dep_ctrl_tb
`default_nettype wire
